// >>> src/txs_exec_top.sv
// Purpose: execution of table read/write, zero-test skip and xor instructions
// Assumes: APB master holds each request until pready; pclk 100 MHz
// Notes: instruction issued by writing its word; runs in four-phase cycles
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module txs_exec_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [txs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);
  import txs_pkg::*;

  txs_mem_if #(.AW(DM_AW)) dm ();
  txs_mem_if #(.AW(PM_AW)) pm ();

  txs_state_type state, next_state;
  txs_op_type op, next_op;
  logic [1:0] q, next_q;
  logic [1:0] mode, next_mode;
  logic [15:0] instr, next_instr;
  logic [7:0] acc, next_acc;
  logic [PTR_W-1:0] ptr, next_ptr;
  logic [7:0] latch, next_latch;
  logic [3:0] bank_select_register, next_bsr;
  logic [DM_AW-1:0] fsr2, next_fsr2;
  logic [DM_AW-1:0] maddr, next_maddr;
  logic [DM_AW-1:0] eff_addr, next_eff_addr;
  logic [7:0] result, next_result;
  logic [7:0] hold_tmp, next_hold_tmp;
  logic [7:0] cycles, next_cycles;
  logic extended_set_enable, next_extended_set_enable;
  logic two_word, next_two_word;
  logic flag_n, next_flag_n;
  logic flag_z, next_flag_z;
  logic skip, next_skip;
  logic next_pready, next_pslverr, next_busy;
  logic [31:0] next_prdata;
  logic hold_we;
  logic [8*HOLD_N-1:0] hold_q;
  logic access, fire, wr_ok;
  txs_op_type new_op;

  txs_data_ram u_dram (
    .pclk(pclk),
    .bus(dm.mem)
  );

  txs_table_mem u_tmem (
    .pclk(pclk),
    .presetn(presetn),
    .bus(pm.mem),
    .hold_we(hold_we),
    .hold_idx(ptr[2:0]),
    .hold_wdata(hold_tmp),
    .hold_q(hold_q)
  );

  function automatic txs_op_type decode(input logic [15:0] w);
    if (w[15:2] == OPC_TABLE_READ_OP)
    begin
      decode = OPK_TABLE_READ_OP;
    end
    else if (w[15:2] == OPC_TABLE_WRITE_OP)
    begin
      decode = OPK_TABLE_WRITE_OP;
    end
    else if (w[15:9] == OPC_TST)
    begin
      decode = OPK_TST;
    end
    else if (w[15:8] == OPC_XORL)
    begin
      decode = OPK_XORL;
    end
    else if (w[15:10] == OPC_XORF)
    begin
      decode = OPK_XORF;
    end
    else
    begin
      decode = OPK_NONE;
    end
  endfunction

  // operand address for register-addressed instructions
  function automatic logic [DM_AW-1:0] resolve(input logic [7:0] f, input logic a,
                                               input logic xi, input logic [3:0] b,
                                               input logic [DM_AW-1:0] base);
    if (!a && xi && f <= INDEX_LIMIT)
    begin
      resolve = base + {4'h0, f};
    end
    else if (!a)
    begin
      resolve = (f > INDEX_LIMIT) ? {ACCESS_HI_BANK, f} : {4'h0, f};
    end
    else
    begin
      resolve = {b, f};
    end
  endfunction

  always_comb
  begin
    next_state = state;
    next_op = op;
    next_q = q;
    next_mode = mode;
    next_instr = instr;
    next_acc = acc;
    next_ptr = ptr;
    next_latch = latch;
    next_bsr = bank_select_register;
    next_fsr2 = fsr2;
    next_maddr = maddr;
    next_eff_addr = eff_addr;
    next_result = result;
    next_hold_tmp = hold_tmp;
    next_cycles = cycles;
    next_extended_set_enable = extended_set_enable;
    next_two_word = two_word;
    next_flag_n = flag_n;
    next_flag_z = flag_z;
    next_skip = skip;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h0;
    hold_we = 1'b0;
    dm.addr = eff_addr;
    dm.wdata = result;
    dm.we = 1'b0;
    pm.addr = ptr[PM_AW-1:0];
    pm.wdata = pwdata[7:0];
    pm.we = 1'b0;

    access = psel && penable;
    fire = access && pready;
    wr_ok = fire && pwrite && !pslverr;
    new_op = decode(pwdata[15:0]);

    // bus answer one cycle into the access phase; memory data needs that edge
    if (access && !pready)
    begin
      next_pready = 1'b1;
      if (pwrite && busy)
      begin
        next_pslverr = 1'b1;
      end
      else if (paddr == OFF_CTRL)
      begin
        next_prdata = {30'h0, two_word, extended_set_enable};
      end
      else if (paddr == OFF_INSTR)
      begin
        next_prdata = {16'h0, instr};
        next_pslverr = pwrite && (new_op == OPK_NONE);
      end
      else if (paddr == OFF_ACC)
      begin
        next_prdata = {24'h0, acc};
      end
      else if (paddr == OFF_PTR)
      begin
        next_prdata = {11'h0, ptr};
      end
      else if (paddr == OFF_LATCH)
      begin
        next_prdata = {24'h0, latch};
      end
      else if (paddr == OFF_STATUS)
      begin
        next_prdata = {16'h0, cycles, 4'h0, flag_n, flag_z, skip, busy};
        next_pslverr = pwrite;
      end
      else if (paddr == OFF_BSR)
      begin
        next_prdata = {28'h0, bank_select_register};
      end
      else if (paddr == OFF_FSR2)
      begin
        next_prdata = {20'h0, fsr2};
      end
      else if (paddr == OFF_MADDR)
      begin
        next_prdata = {20'h0, maddr};
      end
      else if (paddr == OFF_DMEM)
      begin
        next_prdata = busy ? 32'h0 : {24'h0, dm.rdata};
        next_pslverr = busy;
      end
      else if (paddr == OFF_PMEM)
      begin
        next_prdata = busy ? 32'h0 : {24'h0, pm.rdata};
        next_pslverr = busy;
      end
      else if (paddr == OFF_HOLD_LO)
      begin
        next_prdata = hold_q[31:0];
        next_pslverr = pwrite;
      end
      else if (paddr == OFF_HOLD_HI)
      begin
        next_prdata = hold_q[63:32];
        next_pslverr = pwrite;
      end
      else
      begin
        next_pslverr = 1'b1;
      end
    end

    if (state == ST_IDLE)
    begin
      // memories belong to the bus only while nothing executes
      dm.addr = maddr;
      dm.wdata = pwdata[7:0];
      dm.we = wr_ok && paddr == OFF_DMEM;
      pm.addr = maddr[PM_AW-1:0];
      pm.we = wr_ok && paddr == OFF_PMEM;
      if (wr_ok)
      begin
        if (paddr == OFF_CTRL)
        begin
          next_extended_set_enable = pwdata[CTRL_EXTENDED_SET_ENABLE_BIT];
          next_two_word = pwdata[CTRL_TWO_BIT];
        end
        else if (paddr == OFF_ACC)
        begin
          next_acc = pwdata[7:0];
        end
        else if (paddr == OFF_PTR)
        begin
          next_ptr = pwdata[PTR_W-1:0];
        end
        else if (paddr == OFF_LATCH)
        begin
          next_latch = pwdata[7:0];
        end
        else if (paddr == OFF_BSR)
        begin
          next_bsr = pwdata[3:0];
        end
        else if (paddr == OFF_FSR2)
        begin
          next_fsr2 = pwdata[DM_AW-1:0];
        end
        else if (paddr == OFF_MADDR)
        begin
          next_maddr = pwdata[DM_AW-1:0];
        end
        else if (paddr == OFF_INSTR)
        begin
          next_instr = pwdata[15:0];
          next_op = new_op;
          next_mode = pwdata[1:0];
          next_state = ST_CYC1;
          next_q = Q1;
          next_cycles = CYC_ONE;
          next_skip = 1'b0;
        end
      end
    end
    else
    begin
      next_q = q + 2'h1;
    end

    case (state)
      ST_CYC1:
      begin
        if (q == Q1)
        begin
          next_eff_addr = resolve(instr[7:0], instr[8], extended_set_enable, bank_select_register, fsr2);
        end
        else if (q == Q3)
        begin
          if (op == OPK_XORL)
          begin
            next_result = acc ^ instr[7:0];
          end
          else if (op == OPK_XORF)
          begin
            next_result = acc ^ dm.rdata;
          end
          else
          begin
            next_result = dm.rdata;
          end
        end
        else if (q == Q4)
        begin
          if (op == OPK_TABLE_READ_OP || op == OPK_TABLE_WRITE_OP)
          begin
            if (mode == MODE_PREINC)
            begin
              next_ptr = ptr + PTR_ONE;
            end
            next_state = ST_CYC2;
            next_cycles = cycles + CYC_ONE;
          end
          else if (op == OPK_TST)
          begin
            if (result == 8'h00)
            begin
              next_skip = 1'b1;
              next_state = ST_NOP1;
              next_cycles = cycles + CYC_ONE;
            end
            else
            begin
              next_state = ST_IDLE;
            end
          end
          else
          begin
            if (op == OPK_XORF && instr[9])
            begin
              dm.we = 1'b1;
            end
            else
            begin
              next_acc = result;
            end
            next_flag_z = (result == 8'h00);
            next_flag_n = result[7];
            next_state = ST_IDLE;
          end
        end
      end
      ST_CYC2:
      begin
        if (q == Q2 && op == OPK_TABLE_WRITE_OP)
        begin
          next_hold_tmp = latch;
        end
        else if (q == Q3 && op == OPK_TABLE_READ_OP)
        begin
          next_hold_tmp = pm.rdata;
        end
        else if (q == Q4)
        begin
          if (op == OPK_TABLE_READ_OP)
          begin
            next_latch = hold_tmp;
          end
          else
          begin
            hold_we = 1'b1;
          end
          // flags stay untouched by table moves
          if (mode == MODE_POSTINC)
          begin
            next_ptr = ptr + PTR_ONE;
          end
          else if (mode == MODE_POSTDEC)
          begin
            next_ptr = ptr - PTR_ONE;
          end
          next_state = ST_IDLE;
        end
      end
      ST_NOP1:
      begin
        if (q == Q4)
        begin
          if (two_word)
          begin
            next_state = ST_NOP2;
            next_cycles = cycles + CYC_ONE;
          end
          else
          begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_NOP2:
      begin
        if (q == Q4)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
      end
    endcase

    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_IDLE;
      op <= OPK_NONE;
      q <= Q1;
      mode <= MODE_KEEP;
      instr <= 16'h0000;
      acc <= 8'h00;
      ptr <= '0;
      latch <= 8'h00;
      bank_select_register <= 4'h0;
      fsr2 <= '0;
      maddr <= '0;
      eff_addr <= '0;
      result <= 8'h00;
      hold_tmp <= 8'h00;
      cycles <= 8'h00;
      extended_set_enable <= EXTENDED_SET_ENABLE_RESET;
      two_word <= 1'b0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      skip <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      q <= next_q;
      mode <= next_mode;
      instr <= next_instr;
      acc <= next_acc;
      ptr <= next_ptr;
      latch <= next_latch;
      bank_select_register <= next_bsr;
      fsr2 <= next_fsr2;
      maddr <= next_maddr;
      eff_addr <= next_eff_addr;
      result <= next_result;
      hold_tmp <= next_hold_tmp;
      cycles <= next_cycles;
      extended_set_enable <= next_extended_set_enable;
      two_word <= next_two_word;
      flag_n <= next_flag_n;
      flag_z <= next_flag_z;
      skip <= next_skip;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      busy <= next_busy;
    end
  end
endmodule // txs_exec_top

// >>> src/txs_pkg.sv
// Purpose: shared constants and types for the table/xor/skip execution block
// Assumes: 32-bit APB slave, one pclk domain at 100 MHz
// Notes: one instruction cycle is four pclk edges, phases q1..q4
// Contract
// - table read mode in two low opcode bits
// - 21-bit byte pointer, bit 0 selects byte
// - pre-increment before access, post after; flags kept
// - table read two cycles, latch written q4
// - three low pointer bits pick holding register
// - table write shares the four pointer modes
// - table write two cycles, holding written q4
// - zero test skips next instruction with nop
// - skipped two-word instruction costs three cycles
// - bank bit picks access bank or banked
// - extended set, access bank, f<=95 uses indexing
// - xor literal into accumulator, one cycle, flags
// - xor register with accumulator, one cycle, flags
// - destination bit picks accumulator or register
// - extended set enable defaults off
package txs_pkg;
  localparam int ADDR_W = 8;
  localparam int PTR_W = 21;
  localparam int PM_AW = 10;
  localparam int DM_AW = 12;
  localparam int HOLD_N = 8;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACC = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PTR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_LATCH = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_BSR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_FSR2 = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_MADDR = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_DMEM = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_PMEM = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_HOLD_LO = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_HOLD_HI = 8'h30;

  localparam int CTRL_EXTENDED_SET_ENABLE_BIT = 0;
  localparam int CTRL_TWO_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SKIP_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_N_BIT = 3;
  localparam int ST_CYC_LSB = 8;

  localparam logic [13:0] OPC_TABLE_READ_OP = 14'h0002;
  localparam logic [13:0] OPC_TABLE_WRITE_OP = 14'h0003;
  localparam logic [6:0] OPC_TST = 7'h33;
  localparam logic [7:0] OPC_XORL = 8'h0a;
  localparam logic [5:0] OPC_XORF = 6'h06;

  localparam logic [1:0] MODE_KEEP = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_POSTDEC = 2'h2;
  localparam logic [1:0] MODE_PREINC = 2'h3;

  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;

  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [PTR_W-1:0] PTR_ONE = 21'h000001;
  localparam logic [7:0] CYC_ONE = 8'h01;
  localparam logic [7:0] HOLD_RESET = 8'hff;
  localparam logic EXTENDED_SET_ENABLE_RESET = 1'b0;

  typedef enum logic [2:0] {ST_IDLE, ST_CYC1, ST_CYC2, ST_NOP1, ST_NOP2} txs_state_type;
  typedef enum logic [2:0] {OPK_NONE, OPK_TABLE_READ_OP, OPK_TABLE_WRITE_OP, OPK_TST, OPK_XORL, OPK_XORF}
    txs_op_type;
endpackage

// >>> src/txs_mem_if.sv
// Purpose: simple synchronous memory port between exec core and its memories
// Assumes: read data appears one edge after the address
// Notes: write happens at the edge where we is high
`timescale 1ns/1ps
interface txs_mem_if #(parameter int AW = 12);
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic we;
  logic [7:0] rdata;
  modport master (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

// >>> src/txs_data_ram.sv
// Purpose: byte-wide register file for register-addressed operands
// Assumes: 4096 bytes, synchronous read
// Notes: contents are not reset
`timescale 1ns/1ps
module txs_data_ram (
  input wire logic pclk,
  txs_mem_if.mem bus
);
  logic [7:0] mem [0:(1 << txs_pkg::DM_AW)-1];

  always_ff @(posedge pclk)
  begin
    if (bus.we)
    begin
      mem[bus.addr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.addr];
  end
endmodule // txs_data_ram

// >>> src/txs_table_mem.sv
// Purpose: program bytes plus the eight flash holding registers
// Assumes: program store covers only the low pointer bits
// Notes: holding registers reset to erased value
`timescale 1ns/1ps
module txs_table_mem (
  input wire logic pclk,
  input wire logic presetn,
  txs_mem_if.mem bus,
  input wire logic hold_we,
  input wire logic [2:0] hold_idx,
  input wire logic [7:0] hold_wdata,
  output logic [8*txs_pkg::HOLD_N-1:0] hold_q
);
  import txs_pkg::*;
  logic [7:0] mem [0:(1 << PM_AW)-1];

  always_ff @(posedge pclk)
  begin
    if (bus.we)
    begin
      mem[bus.addr] <= bus.wdata;
    end
    bus.rdata <= mem[bus.addr];
  end

  genvar i;
  generate
    for (i = 0; i < HOLD_N; i++)
    begin : g_hold
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          hold_q[8*i +: 8] <= HOLD_RESET;
        end
        else if (hold_we && hold_idx == 3'(i))
        begin
          hold_q[8*i +: 8] <= hold_wdata;
        end
      end
    end
  endgenerate
endmodule // txs_table_mem

// >>> test/txs_flash_model.sv
// Purpose: reference program store and flash holding registers
// Assumes: bench mirrors every program byte it loads
// Notes: holding registers start erased
`timescale 1ns/1ps
module txs_flash_model;
  import txs_pkg::*;
  logic [7:0] pm [0:1023];
  logic [7:0] hold [0:HOLD_N-1];
  initial
  begin
    foreach (hold[i])
      hold[i] = HOLD_RESET;
  end
  // only the low pointer bits reach the store
  function automatic logic [7:0] rd(input logic [PTR_W-1:0] p);
    return pm[p[PM_AW-1:0]];
  endfunction
  task automatic wt(input logic [PTR_W-1:0] p, input logic [7:0] d);
    hold[p[2:0]] = d;
  endtask
  function automatic logic [31:0] bank(input int hi);
    return {hold[4*hi+3], hold[4*hi+2], hold[4*hi+1], hold[4*hi]};
  endfunction
endmodule // txs_flash_model

// >>> test/txs_exec_top_props.sv
// Purpose: port-level checks of the exec block
// Assumes: one pclk domain, presetn async active low
// Notes: busy lengths assume four pclk per instruction cycle
`timescale 1ns/1ps
module txs_exec_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [txs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy
);
  import txs_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ok;
  logic ctrl_set;
  logic two;
  assign ok = pready && pwrite && !pslverr && paddr == OFF_INSTR;
  // skip length depends on the last accepted control word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_set <= 1'b0;
      two <= 1'b0;
    end
    else if (pready && pwrite && !pslverr && paddr == OFF_CTRL)
    begin
      ctrl_set <= 1'b1;
      two <= pwdata[CTRL_TWO_BIT];
    end
  end
  chk_ready_late: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  chk_err_busy: assert property (pready && pwrite && busy |-> pslverr)
    else $error("write while busy accepted");
  chk_err_unmap: assert property (pready && paddr > OFF_HOLD_HI |-> pslverr)
    else $error("unmapped address accepted");
  chk_xorl_len: assert property (
    ok && pwdata[15:8] == OPC_XORL |=> busy [*4] ##1 !busy)
    else $error("xor literal not one cycle");
  chk_xorf_len: assert property (
    ok && pwdata[15:10] == OPC_XORF |=> busy [*4] ##1 !busy)
    else $error("xor register not one cycle");
  chk_table_read_op_len: assert property (
    ok && pwdata[15:2] == OPC_TABLE_READ_OP |=> busy [*8] ##1 !busy)
    else $error("table read not two cycles");
  chk_table_write_op_len: assert property (
    ok && pwdata[15:2] == OPC_TABLE_WRITE_OP |=> busy [*8] ##1 !busy)
    else $error("table write not two cycles");
  chk_skip_len: assert property (
    ok && pwdata[15:9] == OPC_TST |=> busy [*4] ##[1:9] !busy)
    else $error("zero test length out of range");
  chk_skip_short: assert property (
    ok && pwdata[15:9] == OPC_TST && !two |=> busy [*4] ##[1:5] !busy)
    else $error("zero test too long for one-word follower");
  chk_extended_set_enable_off: assert property (
    pready && !pwrite && paddr == OFF_CTRL && !ctrl_set |-> !prdata[CTRL_EXTENDED_SET_ENABLE_BIT])
    else $error("extended set on after reset");
  cov_tst: cover property (ok && pwdata[15:9] == OPC_TST);
  cov_table_write_op: cover property (ok && pwdata[15:2] == OPC_TABLE_WRITE_OP);
  cov_err: cover property (pready && pslverr);
endmodule // txs_exec_props

bind txs_exec_top txs_exec_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy));

// >>> test/test_table_access_xor_skip_exec.sv
// Purpose: self-checking bench for the exec block
// Assumes: apb answer comes within the timeout
// Notes: operands from a fixed-seed lfsr
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module test_table_access_xor_skip_exec;
  import txs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, seed, q;
  logic [PTR_W-1:0] p, ea;
  logic [11:0] oa;
  logic [7:0] acc, lit, dv, res, f;
  logic [1:0] st;
  int errors, check_count, cycles;
  txs_exec_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));
  txs_flash_model i_mdl ();
  always #5 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [PTR_W-1:0] eff(input logic [PTR_W-1:0] x, input logic [1:0] m);
    return (m == MODE_PREINC) ? x + PTR_ONE : x;
  endfunction
  function automatic logic [PTR_W-1:0] nxt(input logic [PTR_W-1:0] x, input logic [1:0] m);
    if (m == MODE_POSTINC || m == MODE_PREINC)
      return x + PTR_ONE;
    return (m == MODE_POSTDEC) ? x - PTR_ONE : x;
  endfunction
  function automatic logic [11:0] opnd(input logic a, input logic xi, input logic [3:0] b,
    input logic [11:0] base, input logic [7:0] ff);
    if (a)
      return {b, ff};
    if (xi && ff <= INDEX_LIMIT)
      return base + {4'h0, ff};
    return (ff < 8'h60) ? {4'h0, ff} : {ACCESS_HI_BANK, ff};
  endfunction
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until the rising edge that sees pready high
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    `CHK(e, ee)
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK(e, ee)
    if (!ee)
      `CHK(q, x)
  endtask
  task automatic run(input logic [15:0] op);
    wr(OFF_INSTR, {16'h0, op}, 1'b0);
    repeat (2) @(negedge pclk);
    while (busy !== 1'b0)
      @(negedge pclk);
  endtask
  task automatic dset(input logic [11:0] a, input logic [7:0] v);
    wr(OFF_MADDR, {20'h0, a}, 1'b0);
    wr(OFF_DMEM, {24'h0, v}, 1'b0);
  endtask
  task automatic complete_run;
    $display("errors %0d check_count %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // guards against a stuck handshake
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("ERROR %0t timeout", $time);
      complete_run;
    end
  end
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    check_count = 0;
    cycles = 0;
    seed = 32'hd9385ce9;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_CTRL, 32'h0, 1'b0);
    rd(OFF_HOLD_LO, 32'hffffffff, 1'b0);
    rd(OFF_HOLD_HI, 32'hffffffff, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(OFF_STATUS, 32'h0, 1'b1);
    for (int k = 0; k < 12; k++)
    begin
      seed = lfsr(seed);
      acc = seed[7:0];
      lit = (k == 0) ? acc : seed[15:8];
      f = (k[2]) ? (seed[23:16] & INDEX_LIMIT) : seed[23:16];
      wr(OFF_ACC, {24'h0, acc}, 1'b0);
      if (k < 4)
        run({OPC_XORL, lit});
      else
      begin
        wr(OFF_CTRL, {31'h0, k[2]}, 1'b0);
        wr(OFF_BSR, {28'h0, seed[27:24]}, 1'b0);
        wr(OFF_FSR2, {20'h0, seed[31:24], seed[3:0]}, 1'b0);
        oa = opnd(k[1], k[2], seed[27:24], {seed[31:24], seed[3:0]}, f);
        dset(oa, lit);
        run({OPC_XORF, k[0], k[1], f});
      end
      res = acc ^ lit;
      rd(OFF_ACC, {24'h0, (k >= 4 && k[0]) ? acc : res}, 1'b0);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(q[ST_N_BIT], res[7])
      `CHK(q[ST_Z_BIT], res == 8'h00)
      `CHK(q[15:8], CYC_ONE)
      if (k >= 4 && k[0])
      begin
        wr(OFF_MADDR, {20'h0, oa}, 1'b0);
        rd(OFF_DMEM, {24'h0, res}, 1'b0);
      end
    end
    for (int k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      p = (k == 3) ? 21'h1fffff : seed[20:0];
      ea = eff(p, k[1:0]);
      lit = seed[31:24];
      wr(OFF_PTR, {11'h0, p}, 1'b0);
      apb(1'b0, OFF_STATUS, 32'h0);
      st = q[3:2];
      if (k < 4)
      begin
        wr(OFF_MADDR, {22'h0, ea[9:0]}, 1'b0);
        wr(OFF_PMEM, {24'h0, lit}, 1'b0);
        i_mdl.pm[ea[9:0]] = lit;
        wr(OFF_PTR, {11'h0, p}, 1'b0);
        run({OPC_TABLE_READ_OP, k[1:0]});
        rd(OFF_LATCH, {24'h0, i_mdl.rd(ea)}, 1'b0);
      end
      else
      begin
        wr(OFF_LATCH, {24'h0, lit}, 1'b0);
        run({OPC_TABLE_WRITE_OP, k[1:0]});
        i_mdl.wt(ea, lit);
        rd(OFF_HOLD_LO, i_mdl.bank(0), 1'b0);
        rd(OFF_HOLD_HI, i_mdl.bank(1), 1'b0);
      end
      rd(OFF_PTR, {11'h0, nxt(p, k[1:0])}, 1'b0);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(q[3:2], st)
      `CHK(q[15:8], 8'h02)
    end
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      wr(OFF_CTRL, {30'h0, k[1], 1'b0}, 1'b0);
      wr(OFF_BSR, {28'h0, seed[11:8]}, 1'b0);
      dset({seed[11:8], seed[7:0]}, k[0] ? 8'h00 : (seed[23:16] | 8'h01));
      run({OPC_TST, 1'b1, seed[7:0]});
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(q[ST_SKIP_BIT], k[0])
      `CHK(q[15:8], k[0] ? (k[1] ? 8'h03 : 8'h02) : CYC_ONE)
    end
    // undecodable word is refused; memory reads refused while a table read runs
    wr(OFF_INSTR, 32'h0000ffff, 1'b1);
    wr(OFF_INSTR, {16'h0, OPC_TABLE_READ_OP, MODE_KEEP}, 1'b0);
    rd(OFF_DMEM, 32'h0, 1'b1);
    rd(OFF_PMEM, 32'h0, 1'b1);
    wr(OFF_ACC, 32'h0, 1'b0);
    wr(OFF_INSTR, {16'h0, OPC_XORL, 8'h5a}, 1'b0);
    wr(OFF_ACC, 32'h11, 1'b1);
    run({OPC_XORL, 8'h00});
    rd(OFF_ACC, 32'h5a, 1'b0);
    complete_run;
  end
endmodule // test_table_access_xor_skip_exec
